// file: pkg/sdc_pkg.sv
// sdc_pkg: register map, field layout, reset values, command codes and
// state encoding of the memory init / mode / refresh controller.
// assumes a 32-bit classic wishbone register port and a single clock.
package sdc_pkg;

  // register byte offsets
  localparam logic [7:0] SDC_OFF_SYSCTL  = 8'h00; // system_control_zero
  localparam logic [7:0] SDC_OFF_INITCTL = 8'h04; // init_control
  localparam logic [7:0] SDC_OFF_INITTIM = 8'h08; // init_timing
  localparam logic [7:0] SDC_OFF_MODE    = 8'h0c; // mode_word_register
  localparam logic [7:0] SDC_OFF_REFEN   = 8'h10; // refresh_enable_register
  localparam logic [7:0] SDC_OFF_REFCTL  = 8'h14; // refresh_control
  localparam logic [7:0] SDC_OFF_STATUS  = 8'h18; // status, read only

  // field positions
  localparam int SDC_PRC_LSB  = 0;  // precharge_to_refresh_cycles, 3 bits
  localparam int SDC_INIT_REFRESH_RECOVERY_LSB = 4;  // init_refresh_recovery, 3 bits
  localparam int SDC_INIT_REFRESH_COUNT_LSB = 8;  // init_refresh_count, 4 bits
  localparam int SDC_RFC_LSB  = 0;  // refresh_interval_count, 12 bits
  localparam int SDC_REFRESH_RECOVERY_CYCLES_LSB = 16; // refresh_recovery_cycles, 4 bits
  localparam int SDC_A10      = 10; // all-bank select address line

  // field encodings to memory clock cycles
  localparam logic [3:0] SDC_PRC_BASE  = 4'h3; // 000b means 3 cycles
  localparam logic [3:0] SDC_INIT_REFRESH_RECOVERY_BASE = 4'h3; // 001b means 4 cycles
  localparam logic [4:0] SDC_REFRESH_RECOVERY_CYCLES_BASE = 5'h01; // 0011b means 4 cycles

  // reset values
  localparam logic [11:0] SDC_RST_INITTIM = 12'h210;
  localparam logic [11:0] SDC_RST_MODE    = 12'h000;
  localparam logic [11:0] SDC_RST_RFC     = 12'h2ed;
  localparam logic [3:0]  SDC_RST_REFRESH_RECOVERY_CYCLES    = 4'h3;

  // command pins as they travel together
  typedef struct packed {
    logic select_n;
    logic row_n;
    logic col_n;
    logic write_n;
  } sdc_cmd_t;

  localparam sdc_cmd_t SDC_CMD_DESEL = 4'hf;
  localparam sdc_cmd_t SDC_CMD_PALL  = 4'h2;
  localparam sdc_cmd_t SDC_CMD_REF   = 4'h1;
  localparam sdc_cmd_t SDC_CMD_MRS   = 4'h0;
  localparam sdc_cmd_t SDC_CMD_ACT   = 4'h3;
  localparam sdc_cmd_t SDC_CMD_RD    = 4'h5;
  localparam sdc_cmd_t SDC_CMD_WR    = 4'h4;

  // sequencer states, gray along off, idle, precharge wait, init refresh
  typedef enum logic [2:0] {
    SDC_ST_OFF   = 3'h0,
    SDC_ST_IDLE  = 3'h1,
    SDC_ST_PREW  = 3'h3,
    SDC_ST_IREFW = 3'h2,
    SDC_ST_AREFW = 3'h6
  } sdc_state_t;

endpackage : sdc_pkg

// file: logic/sdc_clk_gen.sv
// sdc_clk_gen: memory clock divider and clock enable sequencing.
// assumes clk_i is the system clock; memory clock runs at half of it.
`timescale 1ns/1ps
`default_nettype none
module sdc_clk_gen #(
  parameter int CKE_WAIT = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  output logic      mclk_o,
  output logic      cke_o,
  output logic      run_o,
  output wire logic tick_o
);

  logic [3:0] wait_cnt;

  // tick marks the edge at which the memory clock rises
  assign tick_o = run_o & ~mclk_o;

  // clock toggles while enabled, clock enable follows after a few cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      mclk_o   <= 1'b0;
      run_o    <= 1'b0;
      cke_o    <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      run_o  <= 1'b1;
      mclk_o <= run_o & ~mclk_o;
      if (tick_o && wait_cnt != 4'(CKE_WAIT))
        wait_cnt <= wait_cnt + 4'h1;
      if (tick_o && wait_cnt == 4'(CKE_WAIT))
        cke_o <= 1'b1;
    end
  end

endmodule : sdc_clk_gen
`default_nettype wire

// file: logic/sdc_ctrl.sv
// sdc_ctrl: memory controller init, mode set and auto refresh sequencer
// with a classic wishbone register slave.
// assumes a single clock; the memory samples pins on memory clock rise.
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl
  import sdc_pkg::*;
#(
  parameter int CKE_WAIT = 2
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             memory_clock_out_o,
  output logic             clock_enable_o,
  output logic             memory_select_n_o,
  output logic             row_strobe_n_o,
  output logic             col_strobe_n_o,
  output logic             write_enable_n_o,
  output logic [11:0]      mem_addr_o
);

  // lane merge for byte enables
  function automatic logic [31:0] sdc_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction : sdc_merge

  logic        external_bus_enable;
  logic [11:0] init_timing;
  logic [11:0] mode_word;
  logic        auto_refresh_enable;
  logic        ref_en_q;
  logic [11:0] refresh_interval_count;
  logic [3:0]  refresh_recovery_cycles;
  logic        init_pend;
  logic        mode_pend;
  logic        ref_due;
  logic        init_done;
  logic [11:0] rcnt;
  logic [4:0]  cnt;
  logic [3:0]  left;
  sdc_state_t  state;
  sdc_cmd_t    cmd_q;
  logic        mclk;
  logic        run;
  logic        tick;

  // memory clock and clock enable
  sdc_clk_gen #(.CKE_WAIT(CKE_WAIT)) u_clk (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (external_bus_enable),
    .mclk_o   (mclk),
    .cke_o    (clock_enable_o),
    .run_o    (run),
    .tick_o   (tick)
  );

  // bus decode
  wire        wb_req   = wb_cyc_i & wb_stb_i;
  wire        wr_fire  = wb_req & wb_we_i & wb_ack_o;
  wire        hit_sys  = wb_adr_i == SDC_OFF_SYSCTL;
  wire        hit_ictl = wb_adr_i == SDC_OFF_INITCTL;
  wire        hit_itim = wb_adr_i == SDC_OFF_INITTIM;
  wire        hit_mode = wb_adr_i == SDC_OFF_MODE;
  wire        hit_ren  = wb_adr_i == SDC_OFF_REFEN;
  wire        hit_rctl = wb_adr_i == SDC_OFF_REFCTL;
  wire        hit_stat = wb_adr_i == SDC_OFF_STATUS;
  wire        init_busy = state == SDC_ST_PREW || state == SDC_ST_IREFW;
  wire        ref_busy  = state == SDC_ST_AREFW;
  wire [31:0] stat_word = {27'h0, mode_pend, ref_busy, init_done,
                           init_busy, clock_enable_o};
  wire [31:0] rd_data =
    hit_sys  ? {31'h0, external_bus_enable} :
    hit_ictl ? {30'h0, init_done, init_pend | init_busy} :
    hit_itim ? {20'h0, init_timing} :
    hit_mode ? {20'h0, mode_word} :
    hit_ren  ? {31'h0, auto_refresh_enable} :
    hit_rctl ? {12'h0, refresh_recovery_cycles, 4'h0,
                refresh_interval_count} :
    hit_stat ? stat_word : 32'h0;
  wire [31:0] wd_m     = sdc_merge(rd_data, wb_dat_i, wb_sel_i);
  wire        wr_init  = wr_fire & hit_ictl & wb_sel_i[0] & wb_dat_i[0];
  wire        wr_mode  = wr_fire & hit_mode & (|wb_sel_i[1:0]);

  // timing fields as memory clock cycle counts
  wire [3:0] prc_cyc  = {1'b0, init_timing[SDC_PRC_LSB +: 3]} + SDC_PRC_BASE;
  wire [3:0] init_refresh_recovery_cyc = {1'b0, init_timing[SDC_INIT_REFRESH_RECOVERY_LSB +: 3]}
                        + SDC_INIT_REFRESH_RECOVERY_BASE;
  wire [3:0] init_refresh_count     = init_timing[SDC_INIT_REFRESH_COUNT_LSB +: 4];
  wire [3:0] init_refresh_count_eff = (init_refresh_count == 4'h0) ? 4'h1 : init_refresh_count;
  wire [4:0] refresh_recovery_cycles_cyc = {1'b0, refresh_recovery_cycles} + SDC_REFRESH_RECOVERY_CYCLES_BASE;

  // register writes take effect at the acknowledged edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      external_bus_enable     <= 1'b0;
      init_timing             <= SDC_RST_INITTIM;
      mode_word               <= SDC_RST_MODE;
      auto_refresh_enable     <= 1'b0;
      refresh_interval_count  <= SDC_RST_RFC;
      refresh_recovery_cycles <= SDC_RST_REFRESH_RECOVERY_CYCLES;
    end else if (wr_fire) begin
      if (hit_sys)  external_bus_enable <= wd_m[0];
      if (hit_itim) init_timing <= wd_m[11:0];
      if (hit_mode) mode_word <= wd_m[11:0];
      if (hit_ren)  auto_refresh_enable <= wd_m[0];
      if (hit_rctl) begin
        refresh_interval_count  <= wd_m[SDC_RFC_LSB +: 12];
        refresh_recovery_cycles <= wd_m[SDC_REFRESH_RECOVERY_CYCLES_LSB +: 4];
      end
    end
  end

  // bus answer: ack one cycle after the request, read data with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req && !wb_ack_o) wb_dat_o <= rd_data;
    end
  end

  // sequencer next-state and command choice
  sdc_state_t  next_state;
  sdc_cmd_t    next_cmd;
  logic [11:0] next_addr;
  logic [4:0]  next_cnt;
  logic [3:0]  next_left;
  logic        take_init;
  logic        take_mode;
  logic        take_ref;
  logic        set_done;

  always_comb begin
    next_state = state;
    next_cmd   = SDC_CMD_DESEL;
    next_addr  = mem_addr_o;
    next_cnt   = cnt;
    next_left  = left;
    take_init  = 1'b0;
    take_mode  = 1'b0;
    take_ref   = 1'b0;
    set_done   = 1'b0;
    if (!run) begin
      next_state = SDC_ST_OFF;
    end else if (tick) begin
      case (state)
        SDC_ST_OFF: next_state = SDC_ST_IDLE;
        SDC_ST_IDLE: begin
          if (init_pend) begin
            next_cmd   = SDC_CMD_PALL;
            next_addr  = 12'h0;
            next_addr[SDC_A10] = 1'b1;
            next_cnt   = {1'b0, prc_cyc - 4'h1};
            next_left  = init_refresh_count_eff;
            take_init  = 1'b1;
            next_state = SDC_ST_PREW;
          end else if (mode_pend) begin
            next_cmd  = SDC_CMD_MRS;
            next_addr = mode_word;
            take_mode = 1'b1;
          end else if (auto_refresh_enable && ref_due) begin
            next_cmd   = SDC_CMD_REF;
            next_cnt   = refresh_recovery_cycles_cyc - 5'h01;
            take_ref   = 1'b1;
            next_state = SDC_ST_AREFW;
          end
        end
        SDC_ST_PREW, SDC_ST_IREFW: begin
          if (cnt != 5'h0) begin
            next_cnt = cnt - 5'h01;
          end else if (left != 4'h0) begin
            next_cmd   = SDC_CMD_REF;
            next_cnt   = {1'b0, init_refresh_recovery_cyc - 4'h1};
            next_left  = left - 4'h1;
            next_state = SDC_ST_IREFW;
          end else begin
            set_done   = 1'b1;
            next_state = SDC_ST_IDLE;
          end
        end
        SDC_ST_AREFW: begin
          if (cnt != 5'h0) next_cnt = cnt - 5'h01;
          else next_state = SDC_ST_IDLE;
        end
        default: next_state = SDC_ST_IDLE;
      endcase
    end
  end

  // pins move on the edge that raises the memory clock, or on any edge while the memory clock is stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= SDC_ST_OFF;
      cmd_q      <= SDC_CMD_DESEL;
      mem_addr_o <= 12'h0;
      cnt        <= 5'h0;
      left       <= 4'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      left  <= next_left;
      if (tick || !run) begin
        cmd_q      <= next_cmd;
        mem_addr_o <= next_addr;
      end
    end
  end

  assign memory_clock_out_o = mclk;

  // pin outputs straight from the command flops
  always_comb begin
    memory_select_n_o = cmd_q.select_n;
    row_strobe_n_o    = cmd_q.row_n;
    col_strobe_n_o    = cmd_q.col_n;
    write_enable_n_o  = cmd_q.write_n;
  end

  // pending flags: a new set wins over a same-cycle take
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_pend <= 1'b0;
      mode_pend <= 1'b0;
      init_done <= 1'b0;
    end else begin
      init_pend <= wr_init | (init_pend & ~take_init);
      mode_pend <= wr_mode | (mode_pend & ~take_mode);
      init_done <= set_done | (init_done & ~take_init);
    end
  end

  // refresh interval timer: due on the last tick, never on the take itself
  wire rcnt_hit = tick & ~take_ref & (rcnt <= 12'h001);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_en_q <= 1'b0;
      ref_due  <= 1'b0;
      rcnt     <= 12'h0;
    end else begin
      ref_en_q <= auto_refresh_enable;
      ref_due  <= auto_refresh_enable & ((~ref_en_q) | rcnt_hit
                  | (ref_due & ~take_ref));
      if (take_ref) rcnt <= refresh_interval_count;
      else if (tick && rcnt != 12'h0) rcnt <= rcnt - 12'h001;
    end
  end

  // assertion helpers: ticks since last command, init refresh tally
  logic [7:0] since;
  logic [3:0] tally;
  logic       last_per;
  wire        fire = tick & run & (next_cmd != SDC_CMD_DESEL);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since    <= 8'h0;
      tally    <= 4'h0;
      last_per <= 1'b0;
    end else begin
      if (fire) since <= 8'h01;
      else if (tick && since != 8'hff) since <= since + 8'h01;
      if (fire) last_per <= take_ref;
      if (take_init) tally <= 4'h0;
      else if (fire && next_cmd == SDC_CMD_REF && state != SDC_ST_IDLE)
        tally <= tally + 4'h1;
    end
  end

  a_cmd_on_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    !$stable(cmd_q) && run |-> memory_clock_out_o)
    else $error("command changed away from memory clock rise");

  a_cke_after_clk: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(clock_enable_o) |-> $past(run) && external_bus_enable)
    else $error("clock enable rose without running clock");

  a_idle_deselect: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && state == SDC_ST_IDLE && !init_pend && !mode_pend && !ref_due
    |=> cmd_q == SDC_CMD_DESEL)
    else $error("idle sequencer drove a command");

  a_init_precharge: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && run && state == SDC_ST_IDLE && init_pend
    |=> cmd_q == SDC_CMD_PALL && mem_addr_o[SDC_A10] ##1 init_busy)
    else $error("init request did not start with all-bank precharge");

  a_prc_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && state == SDC_ST_PREW |-> since == {4'h0, prc_cyc})
    else $error("precharge to refresh gap wrong");

  a_init_refresh_recovery_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && state == SDC_ST_IREFW |-> since == {4'h0, init_refresh_recovery_cyc})
    else $error("init refresh recovery wrong");

  a_init_count: assert property (@(posedge clk_i) disable iff (rst_i)
    set_done |-> tally == init_refresh_count_eff ##1 init_done)
    else $error("init refresh count wrong");

  a_mrs_value: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && next_cmd == SDC_CMD_MRS
    |=> cmd_q == SDC_CMD_MRS && mem_addr_o == mode_word)
    else $error("mode register set lost the mode word");

  a_refresh_start: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(auto_refresh_enable) |=> ref_due)
    else $error("refresh enable did not request a refresh");

  a_ref_recovery: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && last_per |-> since > {3'h0, refresh_recovery_cycles_cyc})
    else $error("command inside refresh recovery");

  a_no_access: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_q != SDC_CMD_ACT && cmd_q != SDC_CMD_RD && cmd_q != SDC_CMD_WR)
    else $error("access command issued");

endmodule : sdc_ctrl
`default_nettype wire

// file: tb/sdc_mem_model.sv
// sdc_mem_model: behavioural memory chip that watches the command pins
// and records each command with its memory cycle number.
// assumes the pins only move at a memory clock rise.
`timescale 1ns/1ps
`default_nettype none
module sdc_mem_model
  import sdc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        cke_i,
  input  wire logic        select_n_i,
  input  wire logic        row_n_i,
  input  wire logic        col_n_i,
  input  wire logic        write_n_i,
  input  wire logic [11:0] addr_i,
  output var logic [15:0]  cnt_o,
  output var sdc_cmd_t     cmd_o,
  output var logic [11:0]  addr_o,
  output var logic [31:0]  stamp_o,
  output var logic [7:0]   bad_o
);
  logic [31:0] cyc_n;
  sdc_cmd_t    pins;

  // command word as the memory decodes it
  assign pins = {select_n_i, row_n_i, col_n_i, write_n_i};

  initial begin
    cyc_n   = '0;
    cnt_o   = '0;
    cmd_o   = SDC_CMD_DESEL;
    addr_o  = '0;
    stamp_o = '0;
    bad_o   = '0;
  end

  // sample in mid-cycle, where the pins are settled for the next rise
  always @(negedge mclk_i) begin
    if (cke_i === 1'b1) begin
      cyc_n <= cyc_n + 32'd1;
      if (pins.select_n === 1'b0 && pins !== 4'h7) begin
        cnt_o   <= cnt_o + 16'd1;
        cmd_o   <= pins;
        addr_o  <= addr_i;
        stamp_o <= cyc_n;
        // no access command may reach an idle, unopened memory
        if (pins inside {SDC_CMD_ACT, SDC_CMD_RD, SDC_CMD_WR}) begin
          bad_o <= bad_o + 8'd1;
        end
      end
    end
  end
endmodule : sdc_mem_model
`default_nettype wire

// file: tb/testbench.sv
// testbench: register-level run of the init, mode set and refresh
// controller against a memory model. assumes a 125 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sdc_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        mclk;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [11:0] maddr;
  logic [15:0] cnt;
  sdc_cmd_t    cmd;
  logic [11:0] caddr;
  logic [31:0] stamp;
  logic [7:0]  bad;
  int          err_total;
  int          n_compared;

  sdc_ctrl #(.CKE_WAIT(2)) sdc_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .memory_clock_out_o(mclk),
    .clock_enable_o(cke), .memory_select_n_o(cs_n),
    .row_strobe_n_o(ras_n), .col_strobe_n_o(cas_n),
    .write_enable_n_o(we_n), .mem_addr_o(maddr));

  sdc_mem_model sdc_mem_model_inst (
    .mclk_i(mclk), .cke_i(cke), .select_n_i(cs_n), .row_n_i(ras_n),
    .col_n_i(cas_n), .write_n_i(we_n), .addr_i(maddr), .cnt_o(cnt),
    .cmd_o(cmd), .addr_o(caddr), .stamp_o(stamp), .bad_o(bad));

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (k >= 20) begin
      chk(32'h0, 32'h1);
      summarize();
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  // poll a register until all bits of m are set
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    logic [31:0] q;
    int          k;
    k = 0;
    do begin
      wb(1'b0, a, 32'h0, q);
      k++;
    end while ((q & m) !== m && k < 200);
    chk(q & m, m);
    if (k >= 200) begin
      summarize();
    end
  endtask : poll

  // wait for the next command seen by the memory and judge it
  task automatic wait_cmd(input sdc_cmd_t c, input logic [11:0] a,
                          input logic [11:0] m, output logic [31:0] st);
    logic [15:0] n0;
    int          k;
    n0 = cnt;
    k = 0;
    while (cnt === n0 && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 2000) begin
      chk(32'h0, 32'h1);
      summarize();
    end
    chk({28'h0, cmd}, {28'h0, c});
    chk({20'h0, caddr & m}, {20'h0, a & m});
    st = stamp;
  endtask : wait_cmd

  task automatic t_regs();
    rd(SDC_OFF_INITTIM, 32'h0000_0210);
    rd(SDC_OFF_REFCTL, 32'h0003_02ed);
    rd(SDC_OFF_MODE, 32'h0);
    rd(SDC_OFF_STATUS, 32'h0);
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'h0);
    chk({30'h0, mclk, cke}, 32'h0);
  endtask : t_regs

  task automatic t_clock();
    int k;
    int n;
    wr(SDC_OFF_SYSCTL, 32'h1);
    n = 0;
    k = 0;
    while (cke !== 1'b1 && k < 100) begin
      @(posedge clk_i);
      n = n + ((mclk === 1'b1) ? 1 : 0);
      k++;
    end
    chk({31'h0, cke}, 32'h1);
    chk({31'h0, n >= 2}, 32'h1);
    rd(SDC_OFF_STATUS, 32'h1);
  endtask : t_clock

  task automatic t_init();
    logic [31:0] s0;
    logic [31:0] s1;
    wr(SDC_OFF_INITTIM, 32'h0000_0321);
    repeat (12600) @(posedge clk_i);
    chk({16'h0, cnt}, 32'h0);
    wr(SDC_OFF_INITCTL, 32'h1);
    wait_cmd(SDC_CMD_PALL, 12'h400, 12'h400, s0);
    wait_cmd(SDC_CMD_REF, 12'h0, 12'h0, s1);
    chk(s1 - s0, 32'd4);
    for (int i = 0; i < 2; i++) begin
      s0 = s1;
      wait_cmd(SDC_CMD_REF, 12'h0, 12'h0, s1);
      chk(s1 - s0, 32'd5);
    end
    poll(SDC_OFF_STATUS, 32'h4);
    repeat (60) @(posedge clk_i);
    chk({16'h0, cnt}, 32'd4);
  endtask : t_init

  task automatic t_mode();
    logic [31:0] s;
    wr(SDC_OFF_MODE, 32'h220);
    wait_cmd(SDC_CMD_MRS, 12'h220, 12'hfff, s);
    rd(SDC_OFF_MODE, 32'h220);
  endtask : t_mode

  // a mode set lands inside the refresh recovery window
  task automatic t_refresh();
    logic [31:0] s0;
    logic [31:0] s1;
    wr(SDC_OFF_REFCTL, 32'h0003_001f);
    rd(SDC_OFF_REFCTL, 32'h0003_001f);
    wr(SDC_OFF_REFEN, 32'h1);
    wait_cmd(SDC_CMD_REF, 12'h0, 12'h0, s0);
    wr(SDC_OFF_MODE, 32'h230);
    wait_cmd(SDC_CMD_MRS, 12'h230, 12'hfff, s1);
    chk({31'h0, (s1 - s0) >= 32'd5}, 32'h1);
    for (int i = 0; i < 2; i++) begin
      wait_cmd(SDC_CMD_REF, 12'h0, 12'h0, s1);
      chk(s1 - s0, 32'd32);
      s0 = s1;
    end
    chk({24'h0, bad}, 32'h0);
  endtask : t_refresh

  // free-running system clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // main sequence
  initial begin
    rst_i      = 1'b1;
    cyc        = 1'b0;
    stb        = 1'b0;
    we         = 1'b0;
    adr        = 8'h00;
    sel        = 4'h0;
    wdat       = 32'h0;
    err_total  = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_clock();
    t_init();
    t_mode();
    t_refresh();
    summarize();
  end
endmodule : testbench
`default_nettype wire
